/* logic/fsi_status_irq.sv */
// Forwarding status and interrupt aggregation with an APB register slave
//============================================================================
// Functional notes
// R1 - Loss flag sets only after a synchronized frame
// R2 - Loss flag clears when read, 1 means failure
// R3 - Locked bit follows live engine synchronization
// R4 - Locked bit is zero when mode disabled
// R5 - Global enable gates the interrupt output; events unmasked in evt_mask still raise it with the enable clear
// R6 - Transmit enables at bits 5 and 4
// R7 - Receive port n enable at bit n
// R8 - Summary set by any enabled pending source
// R9 - Summary ignores the global enable
// R10 - Transmit pending clears on its event register read
// R11 - Receive pending clears after cause registers read
// R12 - Interrupt output is summary and global enable, ORed here with any event unmasked in evt_mask
// R13 - Host enables one forwarding kind per port
// R14 - Mode 00 off, 01/10/11 synchronized kinds
module fsi_status_irq import fsi_pkg::*; (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic [FSI_AW-1:0]                   paddr,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [FSI_DW-1:0]                   pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic                                     pready,
  output logic [FSI_DW-1:0]                        prdata,
  output logic                                     pslverr,
  input  wire logic [1:0]                          out0_sync_mode,
  input  wire logic [1:0]                          out1_sync_mode,
  input  wire logic [1:0]                          fwd_engine_sync,
  input  wire logic [1:0]                          fwd_frame_sent,
  input  wire logic [1:0]                          tx_event,
  input  wire logic [1:0]                          tx_isr_read,
  input  wire logic [FSI_NUM_RX*FSI_NUM_SRC-1:0]   rx_cause,
  input  wire logic [FSI_NUM_RX*FSI_NUM_SRC-1:0]   rx_src_read,
  output logic                                     out0_locked,
  output logic                                     out1_locked,
  output logic                                     host_irq
);

  typedef struct packed {
    logic [7:0]                          ctl;
    logic [1:0]                          tx_pend;
    logic [FSI_NUM_RX*FSI_NUM_SRC-1:0]   rx_unread;
    logic [FSI_NUM_EVT-1:0]              evt;
    logic [FSI_NUM_EVT-1:0]              evt_mask;
    logic [FSI_DW-1:0]                   rdata;
    logic                                slverr;
  } fsi_agg_state_t;

  fsi_agg_state_t st;
  fsi_agg_state_t next_st;

  logic [1:0]  port_mode [2];
  logic [1:0]  locked;
  logic [1:0]  loss_flag;
  logic [1:0]  loss_pulse;
  logic [1:0]  fail_clear;
  logic [3:0]  rx_pend;
  logic [5:0]  src_pend;
  logic        summary;
  logic        setup;
  logic        done;
  logic        mapped;
  logic        wr_ok;
  logic        rd_fwd;
  logic [7:0]  forwarding_sync_status;
  logic [7:0]  irq_sts;

  //==========================================================================
  // Per port forwarding trackers
  assign port_mode[0] = out0_sync_mode;
  assign port_mode[1] = out1_sync_mode;

  for (genvar g = 0; g < 2; g++) begin : g_port
    fsi_fwd_port u_port (
      .pclk           (pclk),
      .presetn        (presetn),
      .sync_mode      (port_mode[g]),
      .engine_sync    (fwd_engine_sync[g]),
      .frame_sent     (fwd_frame_sent[g]),
      .fail_clear     (fail_clear[g]),
      .locked         (locked[g]),
      .lock_loss_flag (loss_flag[g]),
      .lock_lost      (loss_pulse[g])
    );
  end

  assign out0_locked = locked[0];
  assign out1_locked = locked[1];

  //==========================================================================
  // Source aggregation
  for (genvar p = 0; p < FSI_NUM_RX; p++) begin : g_rx
    // Pending stays up until every register holding a cause has been read
    assign rx_pend[p] = |st.rx_unread[p*FSI_NUM_SRC +: FSI_NUM_SRC]; // [R11]
  end

  assign src_pend = {st.tx_pend, rx_pend};
  // Global enable is deliberately left out of the summary
  assign summary  = |(src_pend & st.ctl[5:0]); // [R6] [R7] [R8] [R9]
  assign host_irq = (summary && st.ctl[FSI_BIT_INT_EN]) || |(st.evt & st.evt_mask); // [R5] [R12]

  assign forwarding_sync_status = {4'h0, loss_flag, locked}; // [R2] [R3]
  assign irq_sts = {summary, 1'b0, src_pend}; // [R8]

  //==========================================================================
  // APB decode
  assign setup   = psel && !penable;
  assign done    = psel && penable;
  assign pready  = done;
  assign prdata  = st.rdata;
  assign pslverr = st.slverr;
  assign mapped  = fsi_reg_hit(paddr, FSI_IDX_FORWARDING_SYNC_STATUS) || fsi_reg_hit(paddr, FSI_IDX_IRQ_CTL) ||
                   fsi_reg_hit(paddr, FSI_IDX_IRQ_STS) || fsi_reg_hit(paddr, FSI_IDX_EVT_STS) ||
                   fsi_reg_hit(paddr, FSI_IDX_EVT_MASK);
  assign wr_ok   = done && pwrite && pstrb[0] && !st.slverr;
  assign rd_fwd  = done && !pwrite && fsi_reg_hit(paddr, FSI_IDX_FORWARDING_SYNC_STATUS);
  // Only flags actually returned are cleared, so a loss arriving after
  // the setup capture is kept for the next read
  assign fail_clear = rd_fwd ? st.rdata[FSI_BIT_FAIL1:FSI_BIT_FAIL0] : 2'b00; // [R2]

  //==========================================================================
  // Next state
  always_comb begin
    next_st = st;
    // Event sets win over their clears throughout
    next_st.tx_pend   = tx_event | (st.tx_pend & ~tx_isr_read); // [R10]
    next_st.rx_unread = rx_cause | (st.rx_unread & ~rx_src_read); // [R11]
    next_st.evt       = loss_pulse | st.evt;
    if (setup) begin
      next_st.slverr = !mapped;
      next_st.rdata  = '0;
      if (!pwrite) begin
        if (fsi_reg_hit(paddr, FSI_IDX_FORWARDING_SYNC_STATUS)) begin
          next_st.rdata[7:0] = forwarding_sync_status;
        end else if (fsi_reg_hit(paddr, FSI_IDX_IRQ_CTL)) begin
          next_st.rdata[7:0] = st.ctl;
        end else if (fsi_reg_hit(paddr, FSI_IDX_IRQ_STS)) begin
          next_st.rdata[7:0] = irq_sts;
        end else if (fsi_reg_hit(paddr, FSI_IDX_EVT_STS)) begin
          next_st.rdata[FSI_NUM_EVT-1:0] = st.evt;
        end else if (fsi_reg_hit(paddr, FSI_IDX_EVT_MASK)) begin
          next_st.rdata[FSI_NUM_EVT-1:0] = st.evt_mask;
        end
      end
    end
    if (wr_ok) begin
      if (fsi_reg_hit(paddr, FSI_IDX_IRQ_CTL)) begin
        next_st.ctl = pwdata[7:0] & FSI_CTL_WMASK; // [R5] [R6] [R7]
      end else if (fsi_reg_hit(paddr, FSI_IDX_EVT_STS)) begin
        next_st.evt = loss_pulse | (st.evt & ~pwdata[FSI_NUM_EVT-1:0]);
      end else if (fsi_reg_hit(paddr, FSI_IDX_EVT_MASK)) begin
        next_st.evt_mask = pwdata[FSI_NUM_EVT-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.ctl      <= FSI_CTL_RST;
      st.evt_mask <= FSI_EVT_MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  //==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_IRQ_GATED_BY_ENABLE: assert property ( // [R5]
    !st.ctl[FSI_BIT_INT_EN] && !(|(st.evt & st.evt_mask)) |-> !host_irq)
    else $error("interrupt raised with global enable clear");

  AST_IRQ_FROM_SUMMARY: assert property ( // [R12]
    wr_ok && fsi_reg_hit(paddr, FSI_IDX_IRQ_CTL) && pwdata[FSI_BIT_INT_EN] && summary
    && !(|st.tx_pend & |tx_isr_read) && !(|rx_src_read) && pwdata[5:0] == 6'h3F |=> host_irq)
    else $error("interrupt not raised for enabled pending source");

  AST_TX_ENABLE_BITS: assert property ( // [R6]
    st.tx_pend[1] && st.ctl[FSI_BIT_TX1] |-> summary ##0 irq_sts[FSI_BIT_SUMMARY])
    else $error("transmit port one enable at bit five not honoured");

  AST_RX_ENABLE_BITS: assert property ( // [R7]
    rx_pend[2] && st.ctl[2] |-> summary)
    else $error("receive port two enable not honoured");

  AST_SUMMARY_NO_GLOBAL: assert property ( // [R8] [R9]
    setup && !pwrite && fsi_reg_hit(paddr, FSI_IDX_IRQ_STS) |=>
      prdata[FSI_BIT_SUMMARY] == $past(|(src_pend & st.ctl[5:0])))
    else $error("summary read back does not match enabled pending sources");

  AST_TX_SET_CLEAR: assert property ( // [R10]
    tx_event[0] |=> st.tx_pend[0] ##1 (st.tx_pend[0] || $past(tx_isr_read[0])))
    else $error("transmit pending lost without its register read");

  AST_RX_HOLD: assert property ( // [R11]
    rx_pend[0] && !(|rx_src_read[FSI_NUM_SRC-1:0]) |=> rx_pend[0])
    else $error("receive pending cleared without a cause register read");

  AST_RX_CLEAR: assert property ( // [R11]
    rx_pend[1] && &rx_src_read[2*FSI_NUM_SRC-1:FSI_NUM_SRC]
    && !(|rx_cause[2*FSI_NUM_SRC-1:FSI_NUM_SRC]) |=> !rx_pend[1])
    else $error("receive pending kept after all cause registers read");

  AST_FAIL_READ_CLEARS: assert property ( // [R2]
    setup && !pwrite && fsi_reg_hit(paddr, FSI_IDX_FORWARDING_SYNC_STATUS) && loss_flag[0] ##1
    done && !g_port[0].u_port.loss_now |=> !loss_flag[0])
    else $error("lock loss flag survived its read");

  COV_LOSS_READ: cover property (rd_fwd && prdata[FSI_BIT_FAIL0]);
  COV_IRQ_RISE: cover property ($rose(host_irq));
  COV_RX_CLEARED: cover property ($fell(rx_pend[3]));
  COV_UNMAPPED: cover property (done && pslverr);

endmodule

/* logic/fsi_pkg.sv */
// Shared constants for the forwarding status and interrupt aggregation block
package fsi_pkg;

  //==========================================================================
  // Bus shape
  localparam int FSI_AW = 12;
  localparam int FSI_DW = 32;

  //==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] FSI_IDX_FORWARDING_SYNC_STATUS  = 8'h22;
  localparam logic [7:0] FSI_IDX_IRQ_CTL  = 8'h23;
  localparam logic [7:0] FSI_IDX_IRQ_STS  = 8'h24;
  localparam logic [7:0] FSI_IDX_EVT_STS  = 8'h2A;
  localparam logic [7:0] FSI_IDX_EVT_MASK = 8'h2B;

  //==========================================================================
  // Field positions
  localparam int FSI_BIT_FAIL1   = 3;
  localparam int FSI_BIT_FAIL0   = 2;
  localparam int FSI_BIT_LOCK1   = 1;
  localparam int FSI_BIT_LOCK0   = 0;
  localparam int FSI_BIT_INT_EN  = 7;
  localparam int FSI_BIT_SUMMARY = 7;
  localparam int FSI_BIT_TX1     = 5;
  localparam int FSI_BIT_TX0     = 4;
  localparam int FSI_NUM_RX      = 4;
  localparam int FSI_NUM_SRC     = 3;
  localparam int FSI_NUM_EVT     = 2;

  //==========================================================================
  // Reset values and write masks
  localparam logic [7:0] FSI_CTL_RST      = 8'h00;
  localparam logic [7:0] FSI_CTL_WMASK    = 8'hBF;
  localparam logic [1:0] FSI_EVT_MASK_RST = 2'h0;

  //==========================================================================
  // Synchronized forwarding mode encoding
  typedef enum logic [1:0] {
    FSI_MODE_OFF        = 2'b00,
    FSI_MODE_BASIC      = 2'b01,
    FSI_MODE_INTERLEAVE = 2'b10,
    FSI_MODE_CONCAT     = 2'b11
  } fsi_sync_mode_t;

  function automatic logic fsi_reg_hit(input logic [FSI_AW-1:0] a, input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction

endpackage

/* logic/fsi_fwd_port.sv */
// Per output port synchronized forwarding lock and lock loss tracker
module fsi_fwd_port import fsi_pkg::*; (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] sync_mode,
  input  wire logic       engine_sync,
  input  wire logic       frame_sent,
  input  wire logic       fail_clear,
  output logic            locked,
  output logic            lock_loss_flag,
  output logic            lock_lost
);

  typedef struct packed {
    logic seen;
    logic prev_ok;
    logic fail;
    logic locked;
    logic lost;
  } fsi_port_state_t;

  fsi_port_state_t st;
  fsi_port_state_t next_st;
  logic            enabled;
  logic            loss_now;

  assign enabled  = sync_mode != FSI_MODE_OFF; // [R14]
  // A drop of the engine's lock only counts once a frame has gone out
  assign loss_now = enabled && st.prev_ok && !engine_sync && st.seen; // [R1]

  //==========================================================================
  // Next state
  always_comb begin
    next_st         = st;
    next_st.prev_ok = enabled && engine_sync;
    next_st.locked  = enabled && engine_sync; // [R3] [R4]
    next_st.lost    = loss_now;
    if (!enabled) begin
      next_st.seen = 1'b0;
    end else if (frame_sent && engine_sync) begin
      next_st.seen = 1'b1;
    end
    // Set wins over the read clear so a loss in the read cycle survives
    if (loss_now) begin
      next_st.fail = 1'b1; // [R1]
    end else if (fail_clear) begin
      next_st.fail = 1'b0; // [R2]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign locked         = st.locked;
  assign lock_loss_flag = st.fail;
  assign lock_lost      = st.lost;

  //==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LOCK_FORCED_OFF: assert property ( // [R4]
    (sync_mode == FSI_MODE_OFF) |=> !locked)
    else $error("locked set while synchronized forwarding is off");

  AST_LOCK_FOLLOWS_ENGINE: assert property ( // [R3]
    (sync_mode != FSI_MODE_OFF) && engine_sync |=> locked ##1
      (locked || !$past(engine_sync) || ($past(sync_mode) == FSI_MODE_OFF)))
    else $error("locked does not follow the engine");

  AST_FAIL_NEEDS_FRAME: assert property ( // [R1]
    $rose(lock_loss_flag) |-> $past(st.seen) && $past(enabled) && $past(st.prev_ok))
    else $error("lock loss flagged without a prior synchronized frame");

  AST_FAIL_CLEARS: assert property ( // [R2]
    lock_loss_flag && fail_clear && !loss_now |=> !lock_loss_flag)
    else $error("lock loss flag not cleared by the read");

endmodule

/* verif/fsi_src_model.sv */
// Model of the forwarding engines, transmitters and receive status sources
module fsi_src_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [1:0]  cmd_sync,
  input  wire logic [1:0]  cmd_frame,
  input  wire logic [1:0]  cmd_tx,
  input  wire logic [1:0]  cmd_txrd,
  input  wire logic [11:0] cmd_cause,
  input  wire logic [11:0] cmd_srd,
  output logic      [1:0]  engine_sync,
  output logic      [1:0]  frame_sent,
  output logic      [1:0]  tx_event,
  output logic      [1:0]  tx_isr_read,
  output logic      [11:0] rx_cause,
  output logic      [11:0] rx_src_read
);
  timeunit 1ns;
  timeprecision 1ps;
  // Registered so every event reaches the block cleanly after a clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      engine_sync <= 2'h0;
      frame_sent  <= 2'h0;
      tx_event    <= 2'h0;
      tx_isr_read <= 2'h0;
      rx_cause    <= 12'h000;
      rx_src_read <= 12'h000;
    end else begin
      engine_sync <= cmd_sync;
      frame_sent  <= cmd_frame;
      tx_event    <= cmd_tx;
      tx_isr_read <= cmd_txrd;
      rx_cause    <= cmd_cause;
      rx_src_read <= cmd_srd;
    end
  end
endmodule

/* verif/forwarding_status_irq_aggregator_tb.sv */
// Self-checking bench for the forwarding status and interrupt block
module forwarding_status_irq_aggregator_tb import fsi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0]  pstrb = 4'hF;
  logic [1:0]  m0 = 0, m1 = 0, c_sy = 0, c_fr = 0, c_tx = 0, c_rd = 0, sy, fr, tx, rd;
  logic [11:0] c_ca = 0, c_sr = 0, ca, sr;
  logic        lk0, lk1, irq;
  int          num_errors = 0, n_tests = 0, seed = 32'h7d53;
  logic [7:0]  v;
  always #5 pclk = ~pclk;
  fsi_src_model i_src (.pclk(pclk), .presetn(presetn), .cmd_sync(c_sy), .cmd_frame(c_fr),
    .cmd_tx(c_tx), .cmd_txrd(c_rd), .cmd_cause(c_ca), .cmd_srd(c_sr), .engine_sync(sy),
    .frame_sent(fr), .tx_event(tx), .tx_isr_read(rd), .rx_cause(ca), .rx_src_read(sr));
  fsi_status_irq i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .out0_sync_mode(m0), .out1_sync_mode(m1),
    .fwd_engine_sync(sy), .fwd_frame_sent(fr), .tx_event(tx), .tx_isr_read(rd),
    .rx_cause(ca), .rx_src_read(sr), .out0_locked(lk0), .out1_locked(lk1), .host_irq(irq));
  //==========================================================================
  // Helpers
  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  function automatic logic [31:0] exp_sts(input logic [5:0] pend, input logic [5:0] en);
    return {24'h0, |(pend & en), 1'b0, pend};
  endfunction
  task automatic test_done();
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Caller stands just after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 50) begin
      num_errors++;
      test_done();
    end
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, ad(idx), {24'h0, d}, q, e);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] ex);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, ex);
  endtask
  task automatic pulse(input logic [1:0] f, input logic [1:0] t, input logic [1:0] r,
                       input logic [11:0] c, input logic [11:0] s);
    c_fr <= f; c_tx <= t; c_rd <= r; c_ca <= c; c_sr <= s;
    @(posedge pclk);
    c_fr <= 0; c_tx <= 0; c_rd <= 0; c_ca <= 0; c_sr <= 0;
    repeat (3) @(posedge pclk);
  endtask
  //==========================================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    logic        e;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(ad(FSI_IDX_FORWARDING_SYNC_STATUS), 32'h0);
    rdc(ad(FSI_IDX_IRQ_CTL), 32'h0);
    rdc(ad(FSI_IDX_IRQ_STS), 32'h0);
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      wr(FSI_IDX_IRQ_CTL, v);
      rdc(ad(FSI_IDX_IRQ_CTL), {24'h0, v & 8'hBF});
    end
    apb(1'b0, 12'h0FC, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    // Every synchronized mode locks; the other port stays off while its engine is synced
    for (int p = 0; p < 2; p++) begin
      for (int m = 1; m < 4; m++) begin
        m0 <= p ? 2'b00 : 2'(m); m1 <= p ? 2'(m) : 2'b00; c_sy <= 2'b11;
        repeat (4) @(posedge pclk);
        chk({30'h0, lk1, lk0}, p ? 32'h2 : 32'h1);
        rdc(ad(FSI_IDX_FORWARDING_SYNC_STATUS), p ? 32'h2 : 32'h1);
      end
    end
    m0 <= 2'b01; m1 <= 2'b00; c_sy <= 2'b00;
    repeat (4) @(posedge pclk);
    rdc(ad(FSI_IDX_FORWARDING_SYNC_STATUS), 32'h0);
    m0 <= 2'b00;
    repeat (2) @(posedge pclk);
    m0 <= 2'b01; c_sy <= 2'b01;
    repeat (4) @(posedge pclk);
    pulse(2'b01, 0, 0, 0, 0);
    c_sy <= 2'b00;
    repeat (4) @(posedge pclk);
    rdc(ad(FSI_IDX_FORWARDING_SYNC_STATUS), 32'h4);
    rdc(ad(FSI_IDX_FORWARDING_SYNC_STATUS), 32'h0);
    // The loss also leaves a sticky event that a written one clears
    rdc(ad(FSI_IDX_EVT_STS), 32'h1);
    wr(FSI_IDX_EVT_STS, 8'h01);
    rdc(ad(FSI_IDX_EVT_STS), 32'h0);
    // Transmit interrupt path
    wr(FSI_IDX_IRQ_CTL, 8'h10);
    pulse(0, 2'b01, 0, 0, 0);
    rdc(ad(FSI_IDX_IRQ_STS), exp_sts(6'h10, 6'h10));
    chk({31'h0, irq}, 32'h0);
    wr(FSI_IDX_IRQ_CTL, 8'h90);
    chk({31'h0, irq}, 32'h1);
    wr(FSI_IDX_IRQ_CTL, 8'h80);
    rdc(ad(FSI_IDX_IRQ_STS), exp_sts(6'h10, 6'h00));
    chk({31'h0, irq}, 32'h0);
    wr(FSI_IDX_IRQ_CTL, 8'hA0);
    pulse(0, 2'b10, 2'b01, 0, 0);
    rdc(ad(FSI_IDX_IRQ_STS), exp_sts(6'h20, 6'h20));
    pulse(0, 0, 2'b10, 0, 0);
    rdc(ad(FSI_IDX_IRQ_STS), 32'h0);
    // Receive port 2 with two causing sources
    wr(FSI_IDX_IRQ_CTL, 8'h84);
    pulse(0, 0, 0, 12'h140, 0);
    rdc(ad(FSI_IDX_IRQ_STS), exp_sts(6'h04, 6'h04));
    chk({31'h0, irq}, 32'h1);
    pulse(0, 0, 0, 0, 12'h040);
    rdc(ad(FSI_IDX_IRQ_STS), exp_sts(6'h04, 6'h04));
    pulse(0, 0, 0, 0, 12'h100);
    rdc(ad(FSI_IDX_IRQ_STS), 32'h0);
    chk({31'h0, irq}, 32'h0);
    test_done();
  end
endmodule
